/* File: synth_cfg_pkg.sv */
// Constants, field layouts and reset words for the synthesizer configuration registers
// Behaviour
// - Dither word: bit23 zero, magnitude 22:21, enable 20, restart 19:3, select 011.
// - Dither register resets to 0x10000B: magnitude code 00, enabled, restart one.
// - Charge pump and reference register resets to 0x0AA7E4.
// - Loop enable and LO path register resets to 0x0000E5.
// - Oscillator control register resets to 0x1E2106.
// - Mixer bias and oscillator register resets to 0x000007, bias off.
// - Mixer word: source select bit22, bias bit21, zeros 20:3, select 111.
// - Mixer bias follows the written bias enable bit.
// - Source select zero picks on-chip oscillator, one picks external.
// - Three-pin serial port loads five 24-bit registers.
package synth_cfg_pkg;

	localparam int          WORD_W        = 24;
	localparam int          SEL_W         = 3;
	localparam int          BITCNT_W      = 5;
	localparam logic [4:0]  WORD_LAST_BIT = 5'h17;

	// Register select codes
	localparam logic [2:0] SEL_DITHER = 3'h3;
	localparam logic [2:0] SEL_CPREF  = 3'h4;
	localparam logic [2:0] SEL_LOOPLO = 3'h5;
	localparam logic [2:0] SEL_OSC    = 3'h6;
	localparam logic [2:0] SEL_MIXER  = 3'h7;

	// Reset words
	localparam logic [23:0] RST_DITHER = 24'h10_000B;
	localparam logic [23:0] RST_CPREF  = 24'h0A_A7E4;
	localparam logic [23:0] RST_LOOPLO = 24'h00_00E5;
	localparam logic [23:0] RST_OSC    = 24'h1E_2106;
	localparam logic [23:0] RST_MIXER  = 24'h00_0007;

	// Dither word fields
	typedef struct packed {
		logic        zero_bit;
		logic [1:0]  dither_magnitude_code;
		logic        dither_on;
		logic [16:0] dither_restart_value;
		logic [2:0]  sel;
	} dither_word_t;

	// Mixer word fields
	typedef struct packed {
		logic        unused_top;
		logic        oscillator_source_select;
		logic        mixer_bias_on;
		logic [17:0] zeros;
		logic [2:0]  sel;
	} mixer_word_t;

	// Decoded outputs to the analogue side
	typedef struct packed {
		logic        dither_active;
		logic [3:0]  dither_magnitude;
		logic [16:0] dither_restart_value;
		logic        mixer_bias_on;
		logic        oscillator_external;
	} synth_ctrl_t;

	// Magnitude code to dither amplitude
	function automatic logic [3:0] dither_mag(input logic [1:0] code);
		case (code)
			2'b00:   dither_mag = 4'hF;
			2'b01:   dither_mag = 4'h7;
			2'b10:   dither_mag = 4'h3;
			default: dither_mag = 4'h1;
		endcase
	endfunction

endpackage

/* File: serial_word_rx.sv */
// Three-pin serial shifter that delivers completed 24-bit words
`timescale 1ns/1ps
module serial_word_rx
	import synth_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               resetn,
	// Serial pins, already synchronised
	input  wire logic               sclk_s,
	input  wire logic               sdata_s,
	input  wire logic               latch_s,
	// Word out
	output logic                    word_valid,
	output logic [WORD_W-1:0]       word_q
);
	logic                sclk_prev_q;
	logic                latch_prev_q;
	logic [WORD_W-1:0]   shift_q;
	logic [BITCNT_W-1:0] count_q;
	logic                valid_q;

	////////////////////////////////////////////////////////////
	// Edge history of clock and latch
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sclk_prev_q  <= 1'b0;
			latch_prev_q <= 1'b0;
		end else begin
			sclk_prev_q  <= sclk_s;
			latch_prev_q <= latch_s;
		end
	end

	// Shift MSB first on rising serial clock while latch is low
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			shift_q <= '0;
			count_q <= '0;
		end else if (latch_s && !latch_prev_q) begin
			count_q <= '0;
		end else if (sclk_s && !sclk_prev_q && !latch_s) begin
			shift_q <= {shift_q[WORD_W-2:0], sdata_s};
			if (count_q != 5'h1F)
				count_q <= count_q + 5'h01;
		end
	end

	// A word counts only if exactly 24 bits preceded the latch edge
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			valid_q <= 1'b0;
			word_q  <= '0;
		end else begin
			valid_q <= latch_s && !latch_prev_q && (count_q == WORD_LAST_BIT + 5'h01);
			if (latch_s && !latch_prev_q)
				word_q <= shift_q;
		end
	end

	assign word_valid = valid_q;

endmodule

/* File: synth_dither_and_path_config_regs.sv */
// Configuration register bank for dither, loop, oscillator and mixer control
`timescale 1ns/1ps
module synth_dither_and_path_config_regs
	import synth_cfg_pkg::*;
(
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  resetn,
	// Three-pin serial port
	input  wire logic                  ser_clk,
	input  wire logic                  ser_data,
	input  wire logic                  ser_latch,
	// Raw register words
	output logic [WORD_W-1:0]          cp_ref_word,
	output logic [WORD_W-1:0]          loop_lo_word,
	output logic [WORD_W-1:0]          osc_ctrl_word,
	// Decoded controls
	output synth_cfg_pkg::synth_ctrl_t ctrl
);
	import synth_cfg_pkg::*;

	logic [1:0]          sclk_sync_q;
	logic [1:0]          sdat_sync_q;
	logic [1:0]          latch_sync_q;
	logic                word_valid;
	logic [WORD_W-1:0]   word;
	logic [2:0]          word_sel;
	dither_word_t        dither_q;
	logic [WORD_W-1:0]   cp_ref_q;
	logic [WORD_W-1:0]   loop_lo_q;
	logic [WORD_W-1:0]   osc_q;
	mixer_word_t         mixer_q;
	synth_ctrl_t         ctrl_q;

	////////////////////////////////////////////////////////////
	// Two-stage synchronisers; first stage feeds only the second
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sclk_sync_q  <= '0;
			sdat_sync_q  <= '0;
			latch_sync_q <= '0;
		end else begin
			sclk_sync_q  <= {sclk_sync_q[0], ser_clk};
			sdat_sync_q  <= {sdat_sync_q[0], ser_data};
			latch_sync_q <= {latch_sync_q[0], ser_latch};
		end
	end

	serial_word_rx u_rx (
		.core_clk   (core_clk),
		.resetn     (resetn),
		.sclk_s     (sclk_sync_q[1]),
		.sdata_s    (sdat_sync_q[1]),
		.latch_s    (latch_sync_q[1]),
		.word_valid (word_valid),
		.word_q     (word)
	);

	assign word_sel = word[SEL_W-1:0];

	////////////////////////////////////////////////////////////
	// Dither register; bit 23 forced zero regardless of the host
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			dither_q <= RST_DITHER;
		end else if (word_valid && word_sel == SEL_DITHER) begin
			dither_q          <= word;
			dither_q.zero_bit <= 1'b0;
		end
	end

	// Middle registers keep whole words; their fields belong elsewhere
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cp_ref_q  <= RST_CPREF;
			loop_lo_q <= RST_LOOPLO;
			osc_q     <= RST_OSC;
		end else if (word_valid) begin
			if (word_sel == SEL_CPREF)
				cp_ref_q <= word;
			if (word_sel == SEL_LOOPLO)
				loop_lo_q <= word;
			if (word_sel == SEL_OSC)
				osc_q <= word;
		end
	end

	// Mixer register; reserved bits held at zero
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mixer_q <= RST_MIXER;
		end else if (word_valid && word_sel == SEL_MIXER) begin
			mixer_q            <= word;
			mixer_q.unused_top <= 1'b0;
			mixer_q.zeros      <= '0;
		end
	end

	////////////////////////////////////////////////////////////
	// Decoded controls registered so outputs come from flip-flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= '0;
		end else begin
			ctrl_q.dither_active        <= dither_q.dither_on;
			ctrl_q.dither_magnitude     <= dither_q.dither_on ?
				dither_mag(dither_q.dither_magnitude_code) : 4'h0;
			ctrl_q.dither_restart_value <= dither_q.dither_restart_value;
			ctrl_q.mixer_bias_on        <= mixer_q.mixer_bias_on;
			ctrl_q.oscillator_external  <= mixer_q.oscillator_source_select;
		end
	end

	assign ctrl          = ctrl_q;
	assign cp_ref_word   = cp_ref_q;
	assign loop_lo_word  = loop_lo_q;
	assign osc_ctrl_word = osc_q;

	////////////////////////////////////////////////////////////
	// Assertions; all sample on the core clock, and all but the two reset-word checks and the cover properties sleep through reset
	// Checks that use $past start one edge late, so no reset-time sample feeds them

	// Field layout of the stored words
	a_dither_bit_zero: assert property (@(posedge core_clk) disable iff (!resetn)
		dither_q.zero_bit == 1'b0) else $error("dither bit 23 set");
	a_select_codes: assert property (@(posedge core_clk) disable iff (!resetn)
		dither_q.sel == SEL_DITHER && mixer_q.sel == SEL_MIXER)
		else $error("stored select code wrong");
	a_mixer_reserved: assert property (@(posedge core_clk) disable iff (!resetn)
		mixer_q.unused_top == 1'b0 && mixer_q.zeros == '0)
		else $error("mixer reserved bits set");

	// Write paths: a selected word lands on the edge after it is valid
	a_dither_write: assert property (@(posedge core_clk) disable iff (!resetn)
		word_valid && word_sel == SEL_DITHER |=> dither_q[22:0] == $past(word[22:0]))
		else $error("dither write lost");
	a_mixer_write: assert property (@(posedge core_clk) disable iff (!resetn)
		word_valid && word_sel == SEL_MIXER |=> mixer_q.mixer_bias_on == $past(word[21])
		&& mixer_q.zeros == '0) else $error("mixer write wrong");
	a_cpref_write: assert property (@(posedge core_clk) disable iff (!resetn)
		word_valid && word_sel == SEL_CPREF |=> cp_ref_q == $past(word))
		else $error("charge pump write lost");
	a_looplo_write: assert property (@(posedge core_clk) disable iff (!resetn)
		word_valid && word_sel == SEL_LOOPLO |=> loop_lo_q == $past(word))
		else $error("loop word write lost");
	a_osc_write: assert property (@(posedge core_clk) disable iff (!resetn)
		word_valid && word_sel == SEL_OSC |=> osc_q == $past(word))
		else $error("oscillator write lost");

	// Unselected registers hold their words, refused frames included except for cp_ref_q
	a_select_only: assert property (@(posedge core_clk) disable iff (!resetn)
		word_valid && word_sel != SEL_CPREF |=> $stable(cp_ref_q))
		else $error("unselected register changed");
	a_osc_hold: assert property (@(posedge core_clk) disable iff (!resetn)
		!(word_valid && word_sel == SEL_OSC) |=> $stable(osc_q))
		else $error("oscillator word changed");
	a_dither_hold: assert property (@(posedge core_clk) disable iff (!resetn)
		!(word_valid && word_sel == SEL_DITHER) |=> $stable(dither_q))
		else $error("dither word changed");
	a_looplo_hold: assert property (@(posedge core_clk) disable iff (!resetn)
		!(word_valid && word_sel == SEL_LOOPLO) |=> $stable(loop_lo_q))
		else $error("loop word changed");
	a_mixer_hold: assert property (@(posedge core_clk) disable iff (!resetn)
		!(word_valid && word_sel == SEL_MIXER) |=> $stable(mixer_q))
		else $error("mixer word changed");

	// Decode to the analogue side, one edge behind the registers
	a_bias_follow: assert property (@(posedge core_clk) disable iff (!resetn)
		word_valid && word_sel == SEL_MIXER |=> ##1 ctrl.mixer_bias_on == $past(word[21], 2))
		else $error("bias not following");
	a_osc_select: assert property (@(posedge core_clk) disable iff (!resetn)
		word_valid && word_sel == SEL_MIXER |=> ##1 ctrl.oscillator_external == $past(word[22], 2))
		else $error("oscillator select wrong");
	a_bias_map: assert property (@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> ctrl.mixer_bias_on == $past(mixer_q.mixer_bias_on))
		else $error("bias output wrong");
	a_osc_map: assert property (@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> ctrl.oscillator_external == $past(mixer_q.oscillator_source_select))
		else $error("oscillator output wrong");
	a_restart_pass: assert property (@(posedge core_clk) disable iff (!resetn)
		1'b1 |=> ctrl.dither_restart_value == $past(dither_q.dither_restart_value))
		else $error("restart value wrong");
	a_dither_off: assert property (@(posedge core_clk) disable iff (!resetn)
		!dither_q.dither_on |=> ctrl.dither_magnitude == 4'h0 && !ctrl.dither_active)
		else $error("dither not disabled");
	a_active_on: assert property (@(posedge core_clk) disable iff (!resetn)
		dither_q.dither_on |=> ctrl.dither_active)
		else $error("dither not enabled");
	a_mag_max: assert property (@(posedge core_clk) disable iff (!resetn)
		dither_q.dither_on && dither_q.dither_magnitude_code == 2'b00 |=>
		ctrl.dither_magnitude == 4'hF) else $error("magnitude map wrong");
	a_mag_mid: assert property (@(posedge core_clk) disable iff (!resetn)
		dither_q.dither_on && dither_q.dither_magnitude_code == 2'b01 |=>
		ctrl.dither_magnitude == 4'h7) else $error("magnitude map wrong");
	a_mag_low: assert property (@(posedge core_clk) disable iff (!resetn)
		dither_q.dither_on && dither_q.dither_magnitude_code == 2'b10 |=>
		ctrl.dither_magnitude == 4'h3) else $error("magnitude map wrong");
	a_mag_min: assert property (@(posedge core_clk) disable iff (!resetn)
		dither_q.dither_on && dither_q.dither_magnitude_code == 2'b11 |=>
		ctrl.dither_magnitude == 4'h1) else $error("magnitude map wrong");

	// Reset words, seen on the first edge after release
	a_reset_words: assert property (@(posedge core_clk)
		$rose(resetn) |-> loop_lo_q == RST_LOOPLO && dither_q == RST_DITHER)
		else $error("reset word wrong");
	a_reset_rest: assert property (@(posedge core_clk)
		$rose(resetn) |-> cp_ref_q == RST_CPREF && osc_q == RST_OSC && mixer_q == RST_MIXER)
		else $error("reset word wrong");
	// Decoded outputs read zero in reset, so their reset state shows one edge later
	a_reset_ctrl: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(resetn) |=> ctrl.dither_active && ctrl.dither_magnitude == 4'hF
		&& ctrl.dither_restart_value == RST_DITHER[19:3]
		&& !ctrl.mixer_bias_on && !ctrl.oscillator_external)
		else $error("decoded reset state wrong");

	// Main scenarios
	c_dither_write: cover property (@(posedge core_clk) word_valid && word_sel == SEL_DITHER);
	c_mixer_write:  cover property (@(posedge core_clk) word_valid && word_sel == SEL_MIXER);
	c_low_sel:      cover property (@(posedge core_clk) word_valid && word_sel < SEL_DITHER);
	c_dither_off:   cover property (@(posedge core_clk) word_valid && word_sel == SEL_DITHER
		&& !word[20]);
	c_external_osc: cover property (@(posedge core_clk) ctrl.mixer_bias_on
		&& ctrl.oscillator_external);

endmodule

/* File: cfg_host_model.sv */
// Host serial master model that writes 24-bit configuration words
`timescale 1ns/1ps
module cfg_host_model
	import synth_cfg_pkg::*;
(
	// Clock
	input  wire logic core_clk,
	// Serial pins toward the device
	output logic      ser_clk,
	output logic      ser_data,
	output logic      ser_latch
);
	import synth_cfg_pkg::*;

	// Idle: link clock parked low outside frames
	initial begin
		ser_clk   = 1'b0;
		ser_data  = 1'b0;
		ser_latch = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One frame, MSB first; half of 1 is the fastest pace the device accepts
	task automatic send(input logic [WORD_W-1:0] w, input int nbits, input int half);
		logic [WORD_W-1:0] sh;
		sh = w;
		for (int i = 0; i < nbits; i++) begin
			ser_data = sh[WORD_W-1];
			sh       = {sh[WORD_W-2:0], ~sh[0]};
			repeat (half) @(posedge core_clk);
			#1 ser_clk = 1'b1;
			repeat (half) @(posedge core_clk);
			#1 ser_clk = 1'b0;
		end
		// Data released: show the inverse so a stale bit cannot pass
		repeat (half) @(posedge core_clk);
		#1 ser_data = ~ser_data;
		ser_latch = 1'b1;
		repeat (half) @(posedge core_clk);
		#1 ser_latch = 1'b0;
	endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the synthesizer configuration register bank
`timescale 1ns/1ps
module tb;
	import synth_cfg_pkg::*;
	logic        core_clk;
	logic        resetn;
	logic        ser_clk;
	logic        ser_data;
	logic        ser_latch;
	logic [23:0] cp_ref_word;
	logic [23:0] loop_lo_word;
	logic [23:0] osc_ctrl_word;
	synth_ctrl_t ctrl;
	logic [23:0] e_dither_magnitude_code, e_mix, e_cp, e_lo, e_osc;
	int          bad_count;
	int          checks;

	// 100 MHz clock
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	synth_dither_and_path_config_regs synth_dither_and_path_config_regs_i (
		.core_clk(core_clk), .resetn(resetn), .ser_clk(ser_clk), .ser_data(ser_data),
		.ser_latch(ser_latch), .cp_ref_word(cp_ref_word), .loop_lo_word(loop_lo_word),
		.osc_ctrl_word(osc_ctrl_word), .ctrl(ctrl));
	cfg_host_model cfg_host_model_i (
		.core_clk(core_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));

	////////////////////////////////////////////////////////////////////////////////
	task automatic cmp(input string nm, input logic [23:0] exp, input logic [23:0] got);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Magnitude halves per code step, forced to zero while dither is off
	task automatic cmp_all();
		logic [3:0] mag;
		mag = e_dither_magnitude_code[20] ? (4'hF >> e_dither_magnitude_code[22:21]) : 4'h0;
		cmp("cp_ref_word", e_cp, cp_ref_word);
		cmp("loop_lo_word", e_lo, loop_lo_word);
		cmp("osc_ctrl_word", e_osc, osc_ctrl_word);
		cmp("ctrl", {e_dither_magnitude_code[20], mag, e_dither_magnitude_code[19:3], e_mix[21], e_mix[22]}, ctrl);
	endtask

	task automatic do_reset();
		resetn = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		cmp("cp_ref_word", 24'h0A_A7E4, cp_ref_word);
		cmp("loop_lo_word", 24'h00_00E5, loop_lo_word);
		cmp("osc_ctrl_word", 24'h1E_2106, osc_ctrl_word);
		cmp("ctrl", 24'h00_0000, ctrl);
		resetn = 1'b1;
		e_cp   = 24'h0A_A7E4;
		e_lo   = 24'h00_00E5;
		e_osc  = 24'h1E_2106;
		e_dither_magnitude_code = 24'h10_000B;
		e_mix  = 24'h00_0007;
		repeat (2) @(posedge core_clk);
		#1;
		cmp_all();
	endtask

	// Only a whole 24-bit word may change the register its low bits pick
	task automatic wr(input logic [23:0] w, input int nb, input int half);
		cfg_host_model_i.send(w, nb, half);
		repeat (4) @(posedge core_clk);
		#1;
		if (nb == 24) begin
			case (w[2:0])
				3'h3: e_dither_magnitude_code = {1'b0, w[22:0]};
				3'h4: e_cp = w;
				3'h5: e_lo = w;
				3'h6: e_osc = w;
				3'h7: e_mix = {1'b0, w[22:21], 18'h0_0000, 3'h7};
				default: ;
			endcase
		end
		cmp_all();
	endtask

	task automatic tally_and_finish();
		if (bad_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		bad_count = 0;
		checks    = 0;
		do_reset();
		for (int c = 0; c < 4; c++) begin
			wr({1'b1, c[1:0], 1'b1, 17'h1_FFFF, 3'h3}, 24, 3);
			wr({1'b0, c[1:0], 1'b0, 17'h0_0000, 3'h3}, 24, 3);
		end
		for (int m = 0; m < 4; m++) begin
			wr({1'b1, m[1:0], 18'h3_FFFF, 3'h7}, 24, 5);
		end
		wr(24'hAB_CDE4, 24, 3);
		wr(24'h12_3455, 24, 4);
		wr(24'h0F_0F06, 24, 3);
		for (int s = 0; s < 3; s++) begin
			wr({21'h15_5555, s[2:0]}, 24, 3);
		end
		wr(24'h77_7776, 23, 3);
		wr(24'h55_5554, 25, 3);
		wr(24'h00_0004, 24, 3);
		do_reset();
		tally_and_finish();
	end

	// Watchdog well beyond the roughly 4000 cycles the sequence needs
	initial begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		tally_and_finish();
	end
endmodule
